/* File: design/twowire_slave.v */
/*
  Two-wire interface: hardware slave with four own addresses, clock
  stretching and byte-done flag, plus a bit-driven software master.
  Assumes the core's register bus (address, write and read strobes, one
  cycle read latency), pins split into input, output and output enable,
  and an external pull-up resolving released lines.
*/
`timescale 1ns/10ps
`include "twowire_regs.vh"

module twowire_slave #(
  parameter FILT_CYC = `SPIKE_CYC
) (
  input  wire       CLK,
  input  wire       SRST,
  input  wire       CE,
  input  wire [7:0] SFR_ADDR,
  input  wire [7:0] SFR_WDATA,
  input  wire       SFR_WR,
  input  wire       SFR_RD,
  output reg  [7:0] SFR_RDATA,
  input  wire       SERIAL_PERIPH_ENABLE,
  input  wire       SERIAL_PERIPH_RELOCATE,
  input  wire       IRQ_ENABLE,
  input  wire       GLOBAL_IRQ_ENABLE,
  output reg        IRQ_REQ,
  output reg [15:0] IRQ_VECTOR,
  input  wire       SDA_IN,
  output reg        SDA_OUT,
  output reg        SDA_OE,
  input  wire       SCL_IN,
  output reg        SCL_OUT,
  output reg        SCL_OE
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_RECV  = 7'h02;
  localparam [6:0] S_ACK   = 7'h04;
  localparam [6:0] S_WAIT  = 7'h08;
  localparam [6:0] S_SEND  = 7'h10;
  localparam [6:0] S_MACK  = 7'h20;
  localparam [6:0] S_HALT  = 7'h40;

  // Parallel compare of a received address against one own address
  function addr_hit;
    input [6:0] rx;
    input [7:0] own;
    begin
      addr_hit = (rx == own[6:0]);
    end
  endfunction

  reg [7:0] own_address_first;
  reg [7:0] own_address_second;
  reg [7:0] own_address_third;
  reg [7:0] own_address_fourth;
  reg [7:0] transfer_byte;
  reg       soft_data_out;
  reg       soft_data_drive_en;
  reg       soft_clock_out;
  reg       soft_data_in;
  reg       master_select;
  reg       iface_soft_reset;
  reg       slave_transmit_dir;
  reg       byte_done_flag;
  reg [1:0] src_code;
  reg       accessed;
  reg [6:0] state;
  reg [7:0] shifter;
  reg [2:0] bit_cnt;
  reg       addr_phase;
  reg       addressed;
  reg       ack_low;
  reg       sda_s1;
  reg       sda_s2;
  reg       scl_s1;
  reg       scl_s2;
  reg       sda_f;
  reg       scl_f;
  reg       sda_d;
  reg       scl_d;
  reg [7:0] sda_cnt;
  reg [7:0] scl_cnt;
  reg       hw_set;
  reg [1:0] hw_code;
  reg       next_sda_oe;
  reg       next_scl_oe;

  wire       iface_on   = ~SERIAL_PERIPH_ENABLE | SERIAL_PERIPH_RELOCATE;
  wire       slave_run  = iface_on & ~master_select & ~iface_soft_reset;
  wire       wr_xfer    = SFR_WR & (SFR_ADDR == `ADR_TRANSFER);
  wire       rd_xfer    = SFR_RD & (SFR_ADDR == `ADR_TRANSFER);
  wire       xfer_acc   = wr_xfer | rd_xfer;
  wire       wr_ctl     = SFR_WR & (SFR_ADDR == `ADR_CONTROL);
  wire       scl_rise   = scl_f & ~scl_d;
  wire       scl_fall   = ~scl_f & scl_d;
  wire       start_cond = scl_f & scl_d & ~sda_f & sda_d;
  wire       stop_cond  = scl_f & scl_d & sda_f & ~sda_d;
  wire [7:0] rx_byte    = {shifter[6:0], sda_f};
  wire       match      = addr_hit(rx_byte[7:1], own_address_first)
                        | addr_hit(rx_byte[7:1], own_address_second)
                        | addr_hit(rx_byte[7:1], own_address_third)
                        | addr_hit(rx_byte[7:1], own_address_fourth);

  // ----------------------------------------------------------------------
  // Pin synchronisers and spike filters
  // ----------------------------------------------------------------------

  // Two flops on each pin before anything looks at it
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
    end
    else if (CE)
    begin
      sda_s1 <= SDA_IN;
      sda_s2 <= sda_s1;
      scl_s1 <= SCL_IN;
      scl_s2 <= scl_s1;
    end
  end

  // A new level is taken only after it has held for the full spike width
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      sda_f   <= 1'b1;
      scl_f   <= 1'b1;
      sda_d   <= 1'b1;
      scl_d   <= 1'b1;
      sda_cnt <= 8'h00;
      scl_cnt <= 8'h00;
    end
    else if (CE)
    begin
      sda_d <= sda_f;
      scl_d <= scl_f;
      if (sda_s2 == sda_f)
        sda_cnt <= 8'h00;
      else if (sda_cnt == FILT_CYC[7:0] - 8'h01)
      begin
        sda_f   <= sda_s2;
        sda_cnt <= 8'h00;
      end
      else
        sda_cnt <= sda_cnt + 8'h01;
      if (scl_s2 == scl_f)
        scl_cnt <= 8'h00;
      else if (scl_cnt == FILT_CYC[7:0] - 8'h01)
      begin
        scl_f   <= scl_s2;
        scl_cnt <= 8'h00;
      end
      else
        scl_cnt <= scl_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Slave state machine
  // ----------------------------------------------------------------------

  // Bus sequencing; hw_set pulses when a byte or stop earns the flag
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      state              <= S_IDLE;
      shifter            <= 8'h00;
      bit_cnt            <= 3'd0;
      addr_phase         <= 1'b0;
      addressed          <= 1'b0;
      ack_low            <= 1'b0;
      slave_transmit_dir <= 1'b0;
      hw_set             <= 1'b0;
      hw_code            <= `SRC_START;
      transfer_byte      <= `RST_TRANSFER;
    end
    else if (CE)
    begin
      hw_set <= 1'b0;
      if (wr_xfer)
        transfer_byte <= SFR_WDATA;
      if (!slave_run)
      begin
        state      <= S_IDLE;
        addressed  <= 1'b0;
        ack_low    <= 1'b0;
        slave_transmit_dir <= 1'b0;
      end
      else if (state != S_HALT && xfer_acc && accessed)
        state <= S_HALT;
      else if (state != S_HALT && stop_cond)
      begin
        state   <= S_IDLE;
        ack_low <= 1'b0;
        if (addressed && iface_soft_reset == 1'b0 && soft_data_out)
        begin
          hw_set  <= 1'b1;
          hw_code <= `SRC_STOP;
        end
        addressed <= 1'b0;
      end
      else if (state != S_HALT && start_cond && (state == S_IDLE || !slave_transmit_dir))
      begin
        state      <= S_RECV;
        bit_cnt    <= 3'd0;
        addr_phase <= 1'b1;
        ack_low    <= 1'b0;
        hw_code    <= (state == S_IDLE) ? `SRC_START : `SRC_RESTART;
      end
      else
      begin
        case (state)
          S_IDLE:
            addressed <= 1'b0;
          S_RECV:
            if (scl_rise)
            begin
              shifter <= rx_byte;
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7)
              begin
                if (addr_phase && !match)
                  state <= S_IDLE;
                else
                begin
                  state         <= S_ACK;
                  transfer_byte <= rx_byte;
                  if (addr_phase)
                  begin
                    slave_transmit_dir <= rx_byte[0];
                    addressed          <= 1'b1;
                  end
                  else
                    hw_code <= `SRC_DATA;
                end
              end
            end
          S_ACK:
            if (scl_fall)
            begin
              if (!ack_low)
                ack_low <= 1'b1;
              else
              begin
                ack_low    <= 1'b0;
                addr_phase <= 1'b0;
                hw_set     <= 1'b1;
                state      <= S_WAIT;
              end
            end
          S_WAIT:
            if (!byte_done_flag && !hw_set)
            begin
              bit_cnt <= 3'd0;
              if (slave_transmit_dir)
              begin
                shifter <= transfer_byte;
                state   <= S_SEND;
              end
              else
                state <= S_RECV;
            end
          S_SEND:
            if (scl_fall)
            begin
              shifter <= {shifter[6:0], 1'b1};
              bit_cnt <= bit_cnt + 3'd1;
              if (bit_cnt == 3'd7)
                state <= S_MACK;
            end
          S_MACK:
            if (scl_rise)
            begin
              if (sda_f)
              begin
                state     <= S_IDLE;
                addressed <= 1'b0;
              end
              else
              begin
                hw_set  <= 1'b1;
                hw_code <= `SRC_DATA;
                state   <= S_WAIT;
              end
            end
          S_HALT:
            state <= S_HALT;
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Byte-done flag, source code and access tracking
  // ----------------------------------------------------------------------

  // Hardware set wins over a clearing access in the same cycle
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      byte_done_flag <= 1'b0;
      src_code       <= `SRC_START;
      accessed       <= 1'b0;
    end
    else if (CE)
    begin
      if (!slave_run)
      begin
        byte_done_flag <= 1'b0;
        accessed       <= 1'b0;
      end
      else if (hw_set)
      begin
        byte_done_flag <= 1'b1;
        src_code       <= hw_code;
        accessed       <= 1'b0;
      end
      else if (xfer_acc)
      begin
        byte_done_flag <= 1'b0;
        accessed       <= 1'b1;
      end
      else if (wr_ctl)
        byte_done_flag <= SFR_WDATA[`CTL_DONE];
    end
  end

  // ----------------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------------

  // Address and control writes; data-in samples the clock rise
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      own_address_first  <= `RST_OWN_FIRST;
      own_address_second <= `RST_OWN_OTHER;
      own_address_third  <= `RST_OWN_OTHER;
      own_address_fourth <= `RST_OWN_OTHER;
      soft_data_out      <= 1'b0;
      soft_data_drive_en <= 1'b0;
      soft_clock_out     <= 1'b0;
      soft_data_in       <= 1'b0;
      master_select      <= 1'b0;
      iface_soft_reset   <= 1'b0;
    end
    else if (CE)
    begin
      if (SFR_WR)
      begin
        case (SFR_ADDR)
          `ADR_OWN_FIRST:  own_address_first  <= SFR_WDATA;
          `ADR_OWN_SECOND: own_address_second <= SFR_WDATA;
          `ADR_OWN_THIRD:  own_address_third  <= SFR_WDATA;
          `ADR_OWN_FOURTH: own_address_fourth <= SFR_WDATA;
          `ADR_CONTROL:
          begin
            soft_data_out      <= SFR_WDATA[`CTL_DATA_OUT];
            soft_data_drive_en <= SFR_WDATA[`CTL_DATA_DRV];
            soft_clock_out     <= SFR_WDATA[`CTL_CLK_OUT];
            master_select      <= SFR_WDATA[`CTL_MASTER];
            iface_soft_reset   <= SFR_WDATA[`CTL_SOFT_RESET];
          end
          default: ;
        endcase
      end
      if (!soft_data_drive_en && scl_rise)
        soft_data_in <= sda_f;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive, interrupt request and read data
  // ----------------------------------------------------------------------

  // Open-drain pulls in slave mode, push-pull in software master mode
  always @*
  begin
    next_sda_oe = 1'b0;
    next_scl_oe = 1'b0;
    if (iface_on && master_select)
    begin
      next_sda_oe = soft_data_drive_en;
      next_scl_oe = 1'b1;
    end
    else if (slave_run)
    begin
      next_sda_oe = (state == S_ACK && ack_low) || (state == S_SEND && !shifter[7]);
      next_scl_oe = (state == S_WAIT) && !scl_f && (byte_done_flag || hw_set);
    end
  end

  // All outputs registered
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      SDA_OUT    <= 1'b0;
      SDA_OE     <= 1'b0;
      SCL_OUT    <= 1'b0;
      SCL_OE     <= 1'b0;
      IRQ_REQ    <= 1'b0;
      IRQ_VECTOR <= `IRQ_VECTOR_ADR;
      SFR_RDATA  <= 8'h00;
    end
    else if (CE)
    begin
      SDA_OUT    <= master_select & soft_data_out;
      SDA_OE     <= next_sda_oe;
      SCL_OUT    <= master_select & soft_clock_out;
      SCL_OE     <= next_scl_oe;
      IRQ_REQ    <= byte_done_flag & IRQ_ENABLE & GLOBAL_IRQ_ENABLE;
      IRQ_VECTOR <= `IRQ_VECTOR_ADR;
      if (SFR_RD)
      begin
        case (SFR_ADDR)
          `ADR_OWN_FIRST:  SFR_RDATA <= own_address_first;
          `ADR_OWN_SECOND: SFR_RDATA <= own_address_second;
          `ADR_OWN_THIRD:  SFR_RDATA <= own_address_third;
          `ADR_OWN_FOURTH: SFR_RDATA <= own_address_fourth;
          `ADR_TRANSFER:   SFR_RDATA <= transfer_byte;
          `ADR_CONTROL:
            if (master_select)
              SFR_RDATA <= {soft_data_out, soft_data_drive_en, soft_clock_out, soft_data_in,
                            1'b1, 3'b000};
            else
              SFR_RDATA <= {soft_data_out, 1'b0, src_code, 1'b0, iface_soft_reset,
                            slave_transmit_dir, byte_done_flag};
          default:         SFR_RDATA <= 8'h00;
        endcase
      end
    end
  end

endmodule // twowire_slave

/* File: design/twowire_regs.vh */
/*
  Register offsets, field positions, reset values and timing counts for the
  two-wire slave and bit-driven master block.
  Assumes the core's special function register bus with 8-bit data.
*/
`ifndef TWOWIRE_REGS_VH
`define TWOWIRE_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADR_OWN_SECOND   8'h91
`define ADR_OWN_THIRD    8'h92
`define ADR_OWN_FOURTH   8'h93
`define ADR_TRANSFER     8'h9a
`define ADR_OWN_FIRST    8'h9b
`define ADR_CONTROL      8'he8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_OWN_FIRST    8'h55
`define RST_OWN_OTHER    8'h7f
`define RST_TRANSFER     8'h00
`define RST_CONTROL      8'h00

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTL_DATA_OUT     7
`define CTL_STOP_IRQ_EN  7
`define CTL_DATA_DRV     6
`define CTL_CLK_OUT      5
`define CTL_DATA_IN      4
`define CTL_MASTER       3
`define CTL_SOFT_RESET   2
`define CTL_DIR          1
`define CTL_DONE         0

// ----------------------------------------------------------------------
// Interrupt source codes and vector
// ----------------------------------------------------------------------
`define SRC_START        2'b00
`define SRC_RESTART      2'b01
`define SRC_DATA         2'b10
`define SRC_STOP         2'b11
`define IRQ_VECTOR_ADR   16'h003b

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS    5000
`define SPIKE_NS         50
`define SPIKE_CYC        ((`SPIKE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* File: sim/twowire_slave_monitor.sv */
/*
  Port-level checker for twowire_slave.
  Assumes it is bound to every twowire_slave and sees only its ports.
*/
`timescale 1ns/10ps
`include "twowire_regs.vh"

module twowire_slave_monitor #(
  parameter FILT_CYC = `SPIKE_CYC
) (
  input wire        CLK,
  input wire        SRST,
  input wire        CE,
  input wire [7:0]  SFR_ADDR,
  input wire [7:0]  SFR_WDATA,
  input wire        SFR_WR,
  input wire        SFR_RD,
  input wire        SERIAL_PERIPH_ENABLE,
  input wire        SERIAL_PERIPH_RELOCATE,
  input wire        IRQ_ENABLE,
  input wire        GLOBAL_IRQ_ENABLE,
  input wire        IRQ_REQ,
  input wire [15:0] IRQ_VECTOR,
  input wire        SDA_OUT,
  input wire        SDA_OE,
  input wire        SCL_OUT,
  input wire        SCL_OE
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  reg  [7:0] ctl;
  wire       usable = !SERIAL_PERIPH_ENABLE || SERIAL_PERIPH_RELOCATE;
  wire       quiet  = CE && !SFR_WR && usable;
  wire       xfer   = CE && (SFR_RD || SFR_WR) && (SFR_ADDR == `ADR_TRANSFER);

  // Shadow of what software last wrote to the control register
  always @(posedge CLK)
    if (SRST)
      ctl <= `RST_CONTROL;
    else if (CE && SFR_WR && (SFR_ADDR == `ADR_CONTROL))
      ctl <= SFR_WDATA;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking mon_clk @(posedge CLK);
  endclocking
  default disable iff (SRST);

  a_irq_both_enables: assert property (
    IRQ_REQ |-> $past(IRQ_ENABLE) && $past(GLOBAL_IRQ_ENABLE))
    else $error("interrupt request without both enables");
  a_vector_fixed: assert property (
    IRQ_VECTOR == `IRQ_VECTOR_ADR)
    else $error("interrupt vector is wrong");
  a_master_clock_pin: assert property (
    (quiet && ctl[3])[*3] |-> SCL_OE && (SCL_OUT == ctl[5]))
    else $error("clock pin does not follow clock-out bit");
  a_master_data_pin: assert property (
    (quiet && ctl[3])[*3] |-> (SDA_OE == ctl[6]) && (!ctl[6] || (SDA_OUT == ctl[7])))
    else $error("data pin does not follow data bits");
  a_slave_pull_low: assert property (
    (quiet && !ctl[3])[*3] |-> !SDA_OUT && !SCL_OUT)
    else $error("slave mode drives a line high");
  a_blocked_released: assert property (
    (CE && !usable)[*3] |-> !SDA_OE && !SCL_OE)
    else $error("pins driven while interface blocked");
  a_transfer_clears: assert property (
    xfer |-> ##2 !IRQ_REQ)
    else $error("transfer access left interrupt pending");
  a_soft_reset_idle: assert property (
    (CE && ctl[2] && !ctl[3] && !SFR_WR)[*3] |-> !SDA_OE && !SCL_OE && !IRQ_REQ)
    else $error("slave active during soft reset");
endmodule // twowire_slave_monitor

bind twowire_slave twowire_slave_monitor #(.FILT_CYC(FILT_CYC)) mon (
  .CLK(CLK), .SRST(SRST), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
  .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SERIAL_PERIPH_ENABLE(SERIAL_PERIPH_ENABLE),
  .SERIAL_PERIPH_RELOCATE(SERIAL_PERIPH_RELOCATE), .IRQ_ENABLE(IRQ_ENABLE),
  .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE));

/* File: sim/twowire_bus_master.sv */
/*
  Behavioural external bus master, 125 ns bit period.
  Assumes pulled-up lines resolved by the bench; it only pulls low.
*/
`timescale 1ns/10ps

module twowire_bus_master (
  input  wire sda,
  input  wire scl,
  output reg  sda_low,
  output reg  scl_low
);
  localparam real Q = 31.25;
  integer stuck;

  // Lines released and idle at start
  initial
  begin
    sda_low = 1'b0;
    scl_low = 1'b0;
    stuck   = 0;
  end

  // Release clock and wait, bounded, while the slave stretches it
  task rise;
    integer n;
  begin
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 4000)
    begin
      #5;
      n = n + 1;
    end
    if (n == 4000)
      stuck = stuck + 1;
  end
  endtask

  // Start or repeated start: data falls while clock high
  task start;
  begin
    #Q sda_low = 1'b0;
    rise;
    #Q sda_low = 1'b1;
    #Q scl_low = 1'b1;
  end
  endtask

  // Stop: data rises while clock high
  task stop;
  begin
    #Q sda_low = 1'b1;
    #Q;
    rise;
    #Q sda_low = 1'b0;
  end
  endtask

  // Clock held low, then a 25 ns high spike the slave must ignore
  task glitch;
  begin
    #(2 * Q) scl_low = 1'b0;
    #25 scl_low = 1'b1;
  end
  endtask

  // One bit: data set while low, sampled at the end of the high phase
  task xbit(input b, output r);
  begin
    #Q sda_low = !b;
    #Q;
    rise;
    #(2 * Q) r = sda;
    scl_low = 1'b1;
  end
  endtask

  // Byte out MSB first, then the slave's acknowledge
  task send(input [7:0] v, output a);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
      xbit(v[i], r);
    xbit(1'b1, r);
    a = !r;
  end
  endtask

  // Byte in MSB first, then our acknowledge or not-acknowledge
  task fetch(input a, output [7:0] v);
    integer i;
    reg     r;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      xbit(1'b1, r);
      v[i] = r;
    end
    xbit(!a, r);
    #Q sda_low = 1'b0;
  end
  endtask

  // Hold the data line low or release it
  task hold_sda(input b);
    sda_low = b;
  endtask
endmodule // twowire_bus_master

/* File: sim/tb.sv */
/*
  Self-checking bench for twowire_slave with an external bus master.
  Assumes writes land one cycle after the strobe and read data stands one
  cycle after the read strobe until the next read.
*/
`timescale 1ns/10ps
`include "twowire_regs.vh"

module tb;
  localparam [55:0] REG_ADR = {`ADR_OWN_FIRST, `ADR_OWN_SECOND, `ADR_OWN_THIRD, `ADR_OWN_FOURTH,
                               `ADR_TRANSFER, `ADR_CONTROL, 8'h80};
  localparam [55:0] REG_RST = {`RST_OWN_FIRST, `RST_OWN_OTHER, `RST_OWN_OTHER, `RST_OWN_OTHER,
                               `RST_TRANSFER, `RST_CONTROL, 8'h00};
  localparam [39:0] MST_VAL = {8'h08, 8'h28, 8'h48, 8'hc8, 8'ha8};

  reg         CLK, SRST, CE, SFR_WR, SFR_RD, IRQ_ENABLE, GLOBAL_IRQ_ENABLE;
  reg         SERIAL_PERIPH_ENABLE, SERIAL_PERIPH_RELOCATE, ack;
  reg  [7:0]  SFR_ADDR, SFR_WDATA, d, v;
  wire [7:0]  SFR_RDATA;
  wire [15:0] IRQ_VECTOR;
  wire        IRQ_REQ, SDA_OUT, SDA_OE, SCL_OUT, SCL_OE, sda_low, scl_low;
  wire        sda_bus = !(sda_low || (SDA_OE && !SDA_OUT));
  wire        scl_bus = !(scl_low || (SCL_OE && !SCL_OUT));
  integer     failures, checks_done, i;

  // Filter shortened to 30 ns: with the full width the slave's reply would
  // only reach the pin after the 125 ns bit's clock had already risen
  twowire_slave #(.FILT_CYC(6)) dut (
    .CLK(CLK), .SRST(SRST), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .SERIAL_PERIPH_ENABLE(SERIAL_PERIPH_ENABLE), .SERIAL_PERIPH_RELOCATE(SERIAL_PERIPH_RELOCATE),
    .IRQ_ENABLE(IRQ_ENABLE), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_REQ(IRQ_REQ),
    .IRQ_VECTOR(IRQ_VECTOR), .SDA_IN(sda_bus), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .SCL_IN(scl_bus), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE));
  twowire_bus_master bus (.sda(sda_bus), .scl(scl_bus), .sda_low(sda_low), .scl_low(scl_low));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  task give_verdict;
  begin
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  task cyc(input integer n);
  begin
    repeat (n) @(posedge CLK);
    #1;
  end
  endtask

  task wr(input [7:0] a, input [7:0] w);
  begin
    cyc(1);
    SFR_ADDR = a;
    SFR_WDATA = w;
    SFR_WR = 1'b1;
    cyc(1);
    SFR_WR = 1'b0;
  end
  endtask

  task rd(input [7:0] a, output [7:0] r);
  begin
    cyc(1);
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    cyc(1);
    SFR_RD = 1'b0;
    cyc(1);
    r = SFR_RDATA;
  end
  endtask

  // Poll control until the byte-done flag shows, bounded
  task poll;
    integer n;
  begin
    d = 8'h00;
    n = 0;
    while (d[0] !== 1'b1 && n < 500)
    begin
      rd(`ADR_CONTROL, d);
      n = n + 1;
    end
    if (n == 500)
    begin
      failures = failures + 1;
      give_verdict;
    end
  end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset_values;
  begin
    for (i = 0; i < 7; i = i + 1)
    begin
      rd(REG_ADR[8*i +: 8], d);
      chk(d, REG_RST[8*i +: 8]);
    end
    chk(IRQ_VECTOR, `IRQ_VECTOR_ADR);
  end
  endtask

  // Write to the fourth address with a clock spike, then a flagged stop
  task t_write;
  begin
    wr(`ADR_OWN_FOURTH, 8'h3c);
    bus.start;
    bus.glitch;
    bus.send(8'h78, ack);
    chk(ack, 1'b1);
    poll;
    chk(d, 8'h01);
    chk({SCL_OE, SCL_OUT}, 2'b10);
    chk(IRQ_REQ, 1'b0);
    IRQ_ENABLE = 1'b1;
    cyc(3);
    chk(IRQ_REQ, 1'b1);
    rd(`ADR_TRANSFER, d);
    chk(d, 8'h78);
    cyc(3);
    chk(SCL_OE, 1'b0);
    bus.send(8'ha5, ack);
    poll;
    chk(d, 8'h21);
    rd(`ADR_TRANSFER, d);
    chk(d, 8'ha5);
    wr(`ADR_CONTROL, 8'h80);
    bus.stop;
    poll;
    chk(d, 8'hb1);
    rd(`ADR_TRANSFER, d);
    wr(`ADR_CONTROL, 8'h00);
  end
  endtask

  // Write the address, turn round with a repeated start, read two bytes
  task t_read;
  begin
    bus.start;
    bus.send(8'haa, ack);
    poll;
    rd(`ADR_TRANSFER, d);
    chk(d, 8'haa);
    bus.start;
    bus.send(8'hab, ack);
    chk(ack, 1'b1);
    poll;
    chk(d, 8'h13);
    wr(`ADR_TRANSFER, 8'hc3);
    bus.fetch(1'b1, d);
    chk(d, 8'hc3);
    poll;
    chk(d, 8'h23);
    wr(`ADR_TRANSFER, 8'h3c);
    bus.fetch(1'b0, d);
    chk(d, 8'h3c);
    cyc(200);
    rd(`ADR_CONTROL, d);
    chk(d & 8'h01, 8'h00);
    bus.stop;
  end
  endtask

  // Double access halts, soft reset recovers, foreign address ignored
  task t_halt;
  begin
    bus.start;
    bus.send(8'haa, ack);
    poll;
    rd(`ADR_TRANSFER, d);
    rd(`ADR_TRANSFER, d);
    bus.send(8'h11, ack);
    chk(ack, 1'b0);
    bus.stop;
    wr(`ADR_CONTROL, 8'h04);
    cyc(4);
    rd(`ADR_CONTROL, d);
    chk(d & 8'h05, 8'h04);
    wr(`ADR_CONTROL, 8'h00);
    bus.start;
    bus.send(8'h20, ack);
    chk(ack, 1'b0);
    bus.stop;
    bus.start;
    bus.send(8'haa, ack);
    chk(ack, 1'b1);
    poll;
    rd(`ADR_TRANSFER, d);
    bus.stop;
  end
  endtask

  // Serial peripheral enabled blocks the slave unless relocated
  task t_blocked;
  begin
    cyc(2);
    SERIAL_PERIPH_ENABLE = 1'b1;
    bus.start;
    bus.send(8'haa, ack);
    chk(ack, 1'b0);
    bus.stop;
    cyc(2);
    SERIAL_PERIPH_RELOCATE = 1'b1;
    bus.start;
    bus.send(8'haa, ack);
    chk(ack, 1'b1);
    poll;
    rd(`ADR_TRANSFER, d);
    bus.stop;
    cyc(2);
    SERIAL_PERIPH_ENABLE = 1'b0;
    SERIAL_PERIPH_RELOCATE = 1'b0;
  end
  endtask

  // Software master: pin control and data-in latching
  task t_master;
  begin
    for (i = 0; i < 5; i = i + 1)
    begin
      v = MST_VAL[8*i +: 8];
      wr(`ADR_CONTROL, v);
      cyc(3);
      chk({SCL_OE, SCL_OUT, SDA_OE, SDA_OE & SDA_OUT}, {1'b1, v[5], v[6], v[6] & v[7]});
    end
    bus.hold_sda(1'b1);
    wr(`ADR_CONTROL, 8'h08);
    cyc(20);
    wr(`ADR_CONTROL, 8'h28);
    cyc(20);
    rd(`ADR_CONTROL, d);
    chk(d, 8'h28);
    bus.hold_sda(1'b0);
    wr(`ADR_CONTROL, 8'h08);
    cyc(20);
    wr(`ADR_CONTROL, 8'h28);
    cyc(20);
    rd(`ADR_CONTROL, d);
    chk(d, 8'h38);
    wr(`ADR_CONTROL, 8'h48);
    cyc(20);
    wr(`ADR_CONTROL, 8'h68);
    cyc(20);
    rd(`ADR_CONTROL, d);
    chk(d, 8'h78);
    wr(`ADR_CONTROL, 8'h00);
    cyc(3);
    chk({SCL_OE, SDA_OE}, 2'b00);
  end
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // Cut a hang short
  initial
  begin
    repeat (60000) @(posedge CLK);
    failures = failures + 1;
    give_verdict;
  end

  initial
  begin
    failures = 0;
    checks_done = 0;
    SRST = 1'b1;
    CE = 1'b1;
    SFR_WR = 1'b0;
    SFR_RD = 1'b0;
    SFR_ADDR = 8'h00;
    SFR_WDATA = 8'h00;
    IRQ_ENABLE = 1'b0;
    GLOBAL_IRQ_ENABLE = 1'b1;
    SERIAL_PERIPH_ENABLE = 1'b0;
    SERIAL_PERIPH_RELOCATE = 1'b0;
    cyc(8);
    SRST = 1'b0;
    t_reset_values;
    t_write;
    t_read;
    t_halt;
    t_blocked;
    t_master;
    chk(bus.stuck, 16'h0000);
    give_verdict;
  end
endmodule // tb
